// *** core/power_control_consts.svh ***
`ifndef POWER_CONTROL_CONSTS_SVH
`define POWER_CONTROL_CONSTS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define PWR_CTL0_OFFSET       4'h0
`define PWR_CTL0_RESET        32'h0000c000
`define PWR_ADDR_WIDTH        4

// ----------------------------------------
// field positions
// ----------------------------------------
`define PWR_LEVEL_HI          15
`define PWR_LEVEL_LO          14
`define PWR_CHG_RES_BIT       13
`define PWR_CHG_EN_BIT        12
`define PWR_RUN_LD_BIT        11
`define PWR_DS_LD_BIT         10
`define PWR_RSVD_BIT          9
`define PWR_BKP_WEN_BIT       8
`define PWR_THR_HI            7
`define PWR_THR_LO            5
`define PWR_MON_EN_BIT        4
`define PWR_STB_CLR_BIT       3
`define PWR_WU_CLR_BIT        2
`define PWR_LP_HI             1
`define PWR_LP_LO             0

// ----------------------------------------
// writable bit mask of the lower half
// ----------------------------------------
`define PWR_WRITE_MASK        16'hfdf3

`endif

// *** core/power_control_pkg.sv ***
package power_control_pkg;

	// low-power mode chosen on deep-sleep entry
	typedef enum logic [1:0] {
		lp_deep_sleep,
		lp_deep_sleep_one,
		lp_deep_sleep_two,
		lp_standby
	} low_power_type;

	// controls driven to the analog blocks
	typedef struct packed {
		logic          core_level_high;
		logic          charge_resistor_select;
		logic          battery_charge_enable;
		logic          run_low_drive;
		logic          deepsleep_low_drive;
		logic          backup_write_enable;
		logic [2:0]    supply_monitor_threshold;
		logic          supply_monitor_enable;
		low_power_type low_power_select;
	} power_ctrl_type;

endpackage

// *** core/power_control_zero.sv ***
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "power_control_consts.svh"

// Summary of operation
// R1 - reset and standby wakeup load 0x0000c000
// R2 - half-word and word accesses only
// R3 - software writes reserved bits as zero
// R4 - change level only with PLL off
// R5 - level upper bit: 0 low, 1 high
// R6 - level applied only while PLL enabled
// R7 - bit13 resistor select, bit12 charge enable
// R8 - bit11 low drive in run/sleep
// R9 - bit10 low drive in deep-sleep
// R10 - bit8 gates backup-domain writes
// R11 - bits7:5 supply monitor threshold code
// R12 - bit4 enables supply monitor
// R13 - bit3 write-one clears standby flag
// R14 - bit2 write-one clears wakeup flag
// R15 - bits1:0 pick mode at deep-sleep
// R16 - half-word write touches only its half
module power_control_zero (
	// clock and reset
	input  wire logic                             clk_i,
	input  wire logic                             rst_i,
	input  wire logic                             standby_wakeup_i,
	// wishbone classic slave
	input  wire logic                             cyc_i,
	input  wire logic                             stb_i,
	input  wire logic                             we_i,
	input  wire logic [`PWR_ADDR_WIDTH-1:0]       adr_i,
	input  wire logic [3:0]                       sel_i,
	input  wire logic [31:0]                      dat_i,
	output logic      [31:0]                      dat_o,
	output logic                                  ack_o,
	output logic                                  err_o,
	// system status
	input  wire logic                             pll_enabled_i,
	input  wire logic                             deep_sleep_request_i,
	input  wire logic                             backup_write_req_i,
	// controls to the analog side
	output power_control_pkg::power_ctrl_type     ctrl_o,
	output logic                                  backup_write_grant_o,
	output logic                                  standby_flag_clear_o,
	output logic                                  wakeup_flag_clear_o,
	output logic                                  deep_sleep_entry_o,
	output power_control_pkg::low_power_type      entry_mode_o
);
	import power_control_pkg::*;

	logic [15:0]    value;
	logic [31:0]    rdata;
	logic           ack;
	logic           err;
	logic           wr_lo;
	logic           wr_hi;
	power_ctrl_type ctrl;
	logic           bkp_grant;
	logic           stb_clr;
	logic           wu_clr;
	logic           ds_entry;
	low_power_type  ds_mode;
	logic           ds_seen;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	power_wb_slave #(
		.ADDR_WIDTH(`PWR_ADDR_WIDTH)
	) u_slave (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.cyc_i   (cyc_i),
		.stb_i   (stb_i),
		.we_i    (we_i),
		.adr_i   (adr_i),
		.sel_i   (sel_i),
		.ack_o   (ack),
		.err_o   (err),
		.wr_lo_o (wr_lo),
		.wr_hi_o (wr_hi)
	);

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// reserved bit 9 and the clear bits never store
	wire [15:0] next_value = (dat_i[15:0] & `PWR_WRITE_MASK)
		| (value & ~`PWR_WRITE_MASK); // see R3
	// upper half is reserved: a high write changes nothing
	wire        next_stb   = wr_lo & dat_i[`PWR_STB_CLR_BIT]; // see R13
	wire        next_wu    = wr_lo & dat_i[`PWR_WU_CLR_BIT]; // see R14
	wire        restore    = rst_i | standby_wakeup_i; // see R1

	// stored field image
	always_ff @(posedge clk_i) begin
		if (restore) begin
			value <= 16'(`PWR_CTL0_RESET); // upper half is reserved zero
		end else if (wr_lo) begin // see R16
			value <= next_value;
		end
	end

	// ----------------------------------------
	// control decode
	// ----------------------------------------
	// level high only with upper bit set and pll running
	wire level_high = value[`PWR_LEVEL_HI] & pll_enabled_i; // see R5 see R6 see R4
	wire [31:0] next_rdata = {16'h0000, value}; // flag-clear bits store zero
	power_ctrl_type next_ctrl;
	assign next_ctrl.core_level_high          = level_high;
	assign next_ctrl.charge_resistor_select   = value[`PWR_CHG_RES_BIT]; // see R7
	assign next_ctrl.battery_charge_enable    = value[`PWR_CHG_EN_BIT]; // see R7
	assign next_ctrl.run_low_drive            = value[`PWR_RUN_LD_BIT]; // see R8
	assign next_ctrl.deepsleep_low_drive      = value[`PWR_DS_LD_BIT]; // see R9
	assign next_ctrl.backup_write_enable      = value[`PWR_BKP_WEN_BIT]; // see R10
	assign next_ctrl.supply_monitor_threshold = value[`PWR_THR_HI:`PWR_THR_LO]; // see R11
	assign next_ctrl.supply_monitor_enable    = value[`PWR_MON_EN_BIT]; // see R12
	assign next_ctrl.low_power_select         = low_power_type'(value[`PWR_LP_HI:`PWR_LP_LO]);

	// registered controls and read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl  <= power_ctrl_type'(0);
			rdata <= 32'h00000000;
		end else begin
			ctrl  <= next_ctrl;
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// flag clears and backup gate
	// ----------------------------------------
	// write-one pulses, one cycle each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stb_clr   <= 1'b0;
			wu_clr    <= 1'b0;
			bkp_grant <= 1'b0;
		end else begin
			stb_clr   <= next_stb; // see R13
			wu_clr    <= next_wu; // see R14
			bkp_grant <= backup_write_req_i & value[`PWR_BKP_WEN_BIT]; // see R10
		end
	end

	// ----------------------------------------
	// deep-sleep entry
	// ----------------------------------------
	// one pulse per rising request, mode latched at entry
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ds_seen  <= 1'b0;
			ds_entry <= 1'b0;
			ds_mode  <= lp_deep_sleep;
		end else begin
			ds_seen  <= deep_sleep_request_i;
			ds_entry <= deep_sleep_request_i & ~ds_seen;
			if (deep_sleep_request_i & ~ds_seen) begin
				ds_mode <= low_power_type'(value[`PWR_LP_HI:`PWR_LP_LO]); // see R15
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign dat_o                = rdata;
	assign ack_o                = ack;
	assign err_o                = err;
	assign ctrl_o               = ctrl;
	assign backup_write_grant_o = bkp_grant;
	assign standby_flag_clear_o = stb_clr;
	assign wakeup_flag_clear_o  = wu_clr;
	assign deep_sleep_entry_o   = ds_entry;
	assign entry_mode_o         = ds_mode;

endmodule

// *** core/power_wb_slave.sv ***
`timescale 1ns/1ns
`include "power_control_consts.svh"

module power_wb_slave #(
	parameter int ADDR_WIDTH = `PWR_ADDR_WIDTH
) (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// wishbone classic
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [ADDR_WIDTH-1:0] adr_i,
	input  wire logic [3:0]            sel_i,
	output logic                       ack_o,
	output logic                       err_o,
	// decoded access, one-cycle pulses
	output logic                       wr_lo_o,
	output logic                       wr_hi_o
);

	logic ack;
	logic err;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire request   = cyc_i & stb_i & ~ack & ~err;
	wire hit       = (adr_i == ADDR_WIDTH'(`PWR_CTL0_OFFSET));
	wire sel_lo    = (sel_i[1:0] == 2'h3);
	wire sel_hi    = (sel_i[3:2] == 2'h3);
	// only half-word or word lane groups are legal
	wire width_ok  = (sel_i == 4'h3) | (sel_i == 4'hc) | (sel_i == 4'hf); // see R2
	wire good      = request & hit & width_ok;

	assign ack_o   = ack;
	assign err_o   = err;
	assign wr_lo_o = good & we_i & sel_lo & ~ack; // see R16
	assign wr_hi_o = good & we_i & sel_hi & ~ack;

	// single-cycle answer, dropped after one clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			err <= 1'b0;
		end else begin
			ack <= good;
			err <= request & ~good;
		end
	end

endmodule

// *** test/cpu_bus_model.sv ***
`timescale 1ns/1ns
`include "power_control_consts.svh"
// ----
// processor bus master
// ----
module cpu_bus_model (
	// command from the bench
	input  wire logic                       clk_i,
	input  wire logic                       go_i,
	input  wire logic                       wr_i,
	input  wire logic [`PWR_ADDR_WIDTH-1:0] adr_i,
	input  wire logic [3:0]                 sel_i,
	input  wire logic [31:0]                wdat_i,
	output logic                            done_o,
	output logic                            fail_o,
	output logic      [31:0]                rdat_o,
	// wishbone classic master
	output logic                            cyc_o,
	output logic                            we_o,
	output logic      [`PWR_ADDR_WIDTH-1:0] adr_o,
	output logic      [3:0]                 sel_o,
	output logic      [31:0]                dat_o,
	input  wire logic                       ack_i,
	input  wire logic                       err_i,
	input  wire logic [31:0]                dat_i
);
	// idle bus at time zero
	initial begin
		{cyc_o, we_o, adr_o, sel_o, dat_o, done_o} = '0;
	end
	// one transfer, held until answered
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (cyc_o && (ack_i || err_i)) begin
			cyc_o  <= 1'b0;
			done_o <= 1'b1;
			fail_o <= err_i;
			rdat_o <= dat_i;
			dat_o  <= ~dat_o; // no stale data after release
		end else if (go_i && !cyc_o && !done_o) begin
			cyc_o <= 1'b1;
			we_o  <= wr_i;
			adr_o <= adr_i;
			sel_o <= sel_i;
			dat_o <= wdat_i & 32'h0000fdff;
		end
	end
endmodule

// *** test/power_control_checker.sv ***
`timescale 1ns/1ns
// ----
// port checks
// ----
module power_control_checker (
	// clock, reset and bus
	input wire logic                              clk_i,
	input wire logic                              rst_i,
	input wire logic                              standby_wakeup_i,
	input wire logic                              cyc_i,
	input wire logic                              stb_i,
	input wire logic                              we_i,
	input wire logic [3:0]                        sel_i,
	input wire logic [31:0]                       dat_i,
	input wire logic                              ack_o,
	input wire logic                              err_o,
	// status and controls
	input wire logic                              pll_enabled_i,
	input wire logic                              deep_sleep_request_i,
	input wire logic                              backup_write_req_i,
	input wire power_control_pkg::power_ctrl_type ctrl_o,
	input wire logic                              backup_write_grant_o,
	input wire logic                              standby_flag_clear_o,
	input wire logic                              wakeup_flag_clear_o,
	input wire logic                              deep_sleep_entry_o
);
	import power_control_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// request taken, lower-half write answered
	sequence s_take; cyc_i && stb_i && !ack_o && !err_o; endsequence
	sequence s_wr; cyc_i && stb_i && we_i && sel_i[0] && !ack_o && !err_o ##1 ack_o; endsequence
	sequence s_hi; cyc_i && stb_i && we_i && sel_i == 4'hc && !ack_o && !err_o ##1 ack_o; endsequence
	property p_ack; s_take |=> ack_o || err_o; endproperty
	property p_fld; s_wr |=> ctrl_o[10:0] ==
		{$past(dat_i[13:10], 2), $past(dat_i[8:4], 2), $past(dat_i[1:0], 2)}; endproperty
	property p_lv5; s_wr |=> ctrl_o.core_level_high ==
		($past(dat_i[15], 2) && $past(pll_enabled_i)); endproperty
	property p_lv6; !$past(pll_enabled_i) |-> !ctrl_o.core_level_high; endproperty
	property p_stb; standby_flag_clear_o == (ack_o && $past(we_i && sel_i[0] && dat_i[3])); endproperty
	property p_wuc; wakeup_flag_clear_o == (ack_o && $past(we_i && sel_i[0] && dat_i[2])); endproperty
	property p_wake; standby_wakeup_i && !cyc_i |=> ##1 ctrl_o[10:0] == 11'h000; endproperty
	property p_ent; $rose(deep_sleep_request_i) && !$past(rst_i) |=> deep_sleep_entry_o; endproperty
	property p_hi; s_hi |=> $stable(ctrl_o[10:0]); endproperty
	property p_bkp; backup_write_grant_o ==
		($past(backup_write_req_i) && ctrl_o.backup_write_enable); endproperty
	a_ack: assert property (p_ack) else $error("bus request not answered");
	a_fld: assert property (p_fld) else $error("control fields differ from write");
	a_lv5: assert property (p_lv5) else $error("level decode wrong");
	a_lv6: assert property (p_lv6) else $error("level high with pll off");
	a_stb: assert property (p_stb) else $error("standby clear pulse wrong");
	a_wuc: assert property (p_wuc) else $error("wakeup clear pulse wrong");
	a_wake: assert property (p_wake) else $error("wakeup did not reload");
	a_ent: assert property (p_ent) else $error("no deep-sleep entry pulse");
	a_hi: assert property (p_hi) else $error("upper write changed controls");
	a_bkp: assert property (p_bkp) else $error("backup grant wrong");
endmodule
bind power_control_zero power_control_checker u_power_control_checker (.clk_i, .rst_i,
	.standby_wakeup_i, .cyc_i, .stb_i, .we_i, .sel_i, .dat_i, .ack_o, .err_o, .pll_enabled_i,
	.deep_sleep_request_i, .backup_write_req_i, .ctrl_o, .backup_write_grant_o,
	.standby_flag_clear_o, .wakeup_flag_clear_o, .deep_sleep_entry_o);

// *** test/power_control_zero_tb.sv ***
`timescale 1ns/1ns
// ----
// bench
// ----
module power_control_zero_tb;
	import power_control_pkg::*;
	logic clk_i, rst_i, standby_wakeup_i, pll_enabled_i, deep_sleep_request_i, backup_write_req_i;
	logic go, wr, done, fail, cyc_i, we_i, ack_o, err_o, standby_flag_clear_o, wakeup_flag_clear_o;
	logic deep_sleep_entry_o, backup_write_grant_o;
	logic [3:0] ad, se, adr_i, sel_i;
	logic [31:0] wd, rd, dat_i, dat_o;
	power_ctrl_type ctrl_o;
	low_power_type entry_mode_o;
	int bad_count, n_checks, n_stb, n_wu;
	logic [59:0] rows [4] = '{{32'h0000c000, 12'h000, 16'hc000}, {32'h0000ffff, 12'h7ff, 16'hfdf3},
		{32'h00002aa5, 12'h529, 16'h28a1}, {32'h00001558, 12'h2d4, 16'h1550}};
	cpu_bus_model u_cpu_bus_model (.clk_i, .go_i(go), .wr_i(wr), .adr_i(ad), .sel_i(se),
		.wdat_i(wd), .done_o(done), .fail_o(fail), .rdat_o(rd), .cyc_o(cyc_i), .we_o(we_i),
		.adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i), .ack_i(ack_o), .err_i(err_o), .dat_i(dat_o));
	power_control_zero u_power_control_zero (.clk_i, .rst_i, .standby_wakeup_i, .cyc_i,
		.stb_i(cyc_i), .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .pll_enabled_i,
		.deep_sleep_request_i, .backup_write_req_i, .ctrl_o, .backup_write_grant_o,
		.standby_flag_clear_o, .wakeup_flag_clear_o, .deep_sleep_entry_o, .entry_mode_o);
	// clock and pulse counters
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (standby_flag_clear_o === 1'b1) n_stb++;
		if (wakeup_flag_clear_o === 1'b1) n_wu++;
	end
	task chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, s, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		{go, wr, ad, se, wd} <= {1'b1, w, a, s, d};
		@(posedge clk_i);
		go <= 1'b0;
		while (done !== 1'b1 && t < 50) begin
			@(posedge clk_i);
			t++;
		end
		if (t == 50) bad_count++;
		#1;
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// watchdog
	initial begin
		#100000;
		bad_count++;
		finish_test;
	end
	// main sequence
	initial begin
		{go, wr, ad, se, wd} = '0;
		{rst_i, standby_wakeup_i, pll_enabled_i, deep_sleep_request_i, backup_write_req_i} = 5'h11;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, 4'h0, 4'hf, 0);
		chk("reset read", rd, 32'h0000c000);
		chk("reset ctrl", ctrl_o, 0);
		foreach (rows[i]) begin
			bus(1, 4'h0, 4'hf, rows[i][59:28]);
			chk("ctrl", ctrl_o, rows[i][27:16]);
			chk("grant", backup_write_grant_o, rows[i][22]);
			bus(0, 4'h0, 4'h3, 0);
			chk("read", rd, rows[i][15:0]);
		end
		chk("stb pulses", n_stb, 2);
		chk("wu pulses", n_wu, 2);
		$display("rows done");
		for (int i = 1; i < 3; i++) begin
			@(posedge clk_i);
			pll_enabled_i <= 1'b0;
			bus(1, 4'h0, 4'h3, i << 14);
			chk("gated level", ctrl_o.core_level_high, 0);
			@(posedge clk_i);
			pll_enabled_i <= 1'b1;
			repeat (2) @(posedge clk_i);
			#1 chk("level", ctrl_o.core_level_high, i[1]);
		end
		bus(1, 4'h0, 4'hc, 32'hffff000c);
		chk("upper half", ctrl_o, 12'h800);
		chk("upper pulses", n_stb + n_wu, 4);
		bus(0, 4'h4, 4'hf, 0);
		chk("unmapped", fail, 1);
		bus(1, 4'h0, 4'h1, 0);
		chk("byte write", fail, 1);
		$display("access done");
		for (int i = 0; i < 8; i++) begin
			bus(1, 4'h0, 4'h3, 32'h8000 | i << 5 | i % 4);
			chk("threshold", ctrl_o.supply_monitor_threshold, i);
			@(posedge clk_i);
			deep_sleep_request_i <= 1'b1;
			@(posedge clk_i);
			#1 chk("entry mode", entry_mode_o, i % 4);
			chk("entry pulse", deep_sleep_entry_o, 1);
			@(posedge clk_i);
			deep_sleep_request_i <= 1'b0;
		end
		bus(1, 4'h0, 4'h3, 32'h000080ff);
		@(posedge clk_i);
		standby_wakeup_i <= 1'b1;
		@(posedge clk_i);
		standby_wakeup_i <= 1'b0;
		bus(0, 4'h0, 4'hf, 0);
		chk("wakeup read", rd, 32'h0000c000);
		$display("modes done");
		finish_test;
	end
endmodule
